// File: bulk_iso_fifo_host_port.v
/*
 * Host register port of the bulky isochronous transmit and receive buffers,
 * plus the asynchronous receive trailer and isochronous header registers.
 * Assumes one system clock shared with the link engines, which drive the
 * receive stream, header and trailer inputs and drain the transmit stream.
 */
// Strobed register access was chosen for this implementation.
// What this block does
// - when the asynchronous receive logic finishes a packet, its trailer is copied into the trailer register.
// - the trailer speed field reports 00 for 100 Mbit/s and 01 for 200 Mbit/s, other codes invalid.
// - the trailer pad field gives zero to three padding bytes in the last payload quadlet.
// - the trailer ack field holds the acknowledge code returned for the packet.
// - the size register holds a ten-bit transmit size and a ten-bit receive size in units of four quadlets.
// - the level register reports the free quadlet locations of the transmit buffer.
// - the level register reports the quadlets held in the receive buffer.
// - each write to the continue port appends one quadlet to the transmit buffer without ending the packet, while room is left.
// - a write to the last port, while room is left, tags the quadlet as packet end and releases the packet for sending.
// - each read of the receive port removes and returns the next stored quadlet.
// - a read of the receive port while empty returns the last delivered quadlet and changes nothing.
// - the first receive port read after reset returns zero while the receive buffer is still empty.
// - each received isochronous header is copied into the header register with its fields in place.
// - reset clears the size, level, header and trailer registers to zero.
`timescale 1ns/1ps
`include "bulk_iso_regs.vh"

module bulk_iso_fifo_host_port (
   input  wire         sys_clk_i,
   input  wire         sys_rst_i,
   // register port
   input  wire [11:0]  reg_addr_i,
   input  wire [31:0]  reg_wdata_i,
   input  wire         reg_wr_i,
   input  wire         reg_rd_i,
   output wire [31:0]  reg_rdata_o,
   // transmit stream toward the link transmitter
   output wire [31:0]  tx_data_o,
   output wire         tx_last_o,
   output wire         tx_valid_o,
   input  wire         tx_ready_i,
   // receive stream from the link receiver
   input  wire [31:0]  rx_data_i,
   input  wire         rx_valid_i,
   output wire         rx_ready_o,
   // received isochronous header
   input  wire [31:0]  iso_hdr_i,
   input  wire         iso_hdr_valid_i,
   // finished asynchronous packet trailer
   input  wire [1:0]   rx_speed_code_i,
   input  wire [1:0]   pad_byte_count_i,
   input  wire [3:0]   returned_ack_code_i,
   input  wire         async_done_i
);

   // capacity in quadlets for a programmed size, clipped to the array
   function [11:0] cap_of;
      input [9:0] size;
      reg   [11:0] quads;
      begin
         quads = {size, 2'b00};
         if (quads > `FIFO_CAP) begin
            cap_of = `FIFO_CAP;
         end else begin
            cap_of = quads;
         end
      end
   endfunction

   // true while a count is not zero
   function nonzero;
      input [`FIFO_CW-1:0] cnt;
      begin
         nonzero = (cnt != {`FIFO_CW{1'b0}});
      end
   endfunction

   // register port select for one byte offset
   function at_offset;
      input [11:0] addr;
      input [11:0] offset;
      begin
         at_offset = (addr == offset);
      end
   endfunction

   // registers
   reg  [31:0]          rdata_q;
   reg  [31:0]          trailer_q;
   reg  [9:0]           iso_tx_depth_q;
   reg  [9:0]           iso_rx_depth_q;
   reg  [31:0]          header_q;
   reg  [31:0]          rx_last_q;
   reg  [`FIFO_CW-1:0]  released_q;
   reg  [31:0]          tx_data_q;
   reg                  tx_last_q;
   reg                  tx_valid_q;
   reg                  rx_ready_q;

   // combinational terms
   wire [11:0]          tx_cap;
   wire [11:0]          rx_cap;
   wire [`FIFO_CW-1:0]  tx_count;
   wire [`FIFO_CW-1:0]  rx_count;
   wire [32:0]          tx_head;
   wire [31:0]          rx_head;
   wire [11:0]          tx_count_w;
   wire [11:0]          rx_count_w;
   wire [11:0]          iso_tx_free_count;
   wire [11:0]          iso_rx_fill_count;
   wire                 hit_cont;
   wire                 hit_last;
   wire                 tx_push;
   wire                 tx_pop;
   wire                 rx_push;
   wire                 rx_pop;
   wire [`FIFO_CW-1:0]  rx_count_d;
   reg  [31:0]          rd_mux;
   reg  [31:0]          trailer_d;
   wire [31:0]          size_rst;
   wire                 tx_has_data;
   wire                 rx_has_data;

   // capacities and occupancy counts
   assign tx_cap     = cap_of(iso_tx_depth_q);
   assign rx_cap     = cap_of(iso_rx_depth_q);
   assign tx_count_w = {3'b000, tx_count};
   assign rx_count_w = {3'b000, rx_count};
   assign iso_tx_free_count = (tx_cap > tx_count_w) ? (tx_cap - tx_count_w) : 12'h000;
   assign iso_rx_fill_count = rx_count_w;

   // buffer not empty, shared by the pops and the receive read selection
   assign tx_has_data = nonzero(tx_count);
   assign rx_has_data = nonzero(rx_count);

   // reset image of the size register
   assign size_rst    = `RST_ISO_FIFO_SIZE;

   // transmit pushes from the two write ports, dropped when no room is left
   assign hit_cont = reg_wr_i && at_offset(reg_addr_i, `OFF_ISO_TX_PUSH_CONTINUE);
   assign hit_last = reg_wr_i && at_offset(reg_addr_i, `OFF_ISO_TX_PUSH_LAST);
   assign tx_push  = (hit_cont || hit_last) && (tx_count_w < tx_cap);

   // the output stage only takes quadlets of packets already released
   assign tx_pop = tx_has_data && nonzero(released_q)
                   && (!tx_valid_q || tx_ready_i);

   // receive side: the link pushes while ready, software pops by reading
   assign rx_push = rx_valid_i && rx_ready_q;
   assign rx_pop  = reg_rd_i && at_offset(reg_addr_i, `OFF_ISO_RX_POP)
                    && rx_has_data;

   // receive count as it will stand after this cycle
   assign rx_count_d = rx_count + {8'h00, rx_push} - {8'h00, rx_pop};

   // transmit store, each quadlet carries its end-of-packet tag
   iso_quad_fifo #(
      .W          (33)
   ) u_tx_fifo (
      .sys_clk_i  (sys_clk_i),
      .sys_rst_i  (sys_rst_i),
      .wr_en_i    (tx_push),
      .wr_data_i  ({hit_last, reg_wdata_i}),
      .rd_en_i    (tx_pop),
      .head_o     (tx_head),
      .count_o    (tx_count)
   );

   // receive store
   iso_quad_fifo #(
      .W          (32)
   ) u_rx_fifo (
      .sys_clk_i  (sys_clk_i),
      .sys_rst_i  (sys_rst_i),
      .wr_en_i    (rx_push),
      .wr_data_i  (rx_data_i),
      .rd_en_i    (rx_pop),
      .head_o     (rx_head),
      .count_o    (rx_count)
   );

   // size register, the only one software writes
   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         iso_tx_depth_q <= size_rst[`SZ_TX_LSB +: `SZ_W];
         iso_rx_depth_q <= size_rst[`SZ_RX_LSB +: `SZ_W];
      end else if (reg_wr_i && at_offset(reg_addr_i, `OFF_ISO_FIFO_SIZE)) begin
         iso_tx_depth_q <= reg_wdata_i[`SZ_TX_LSB +: `SZ_W];
         iso_rx_depth_q <= reg_wdata_i[`SZ_RX_LSB +: `SZ_W];
      end
   end

   // trailer word from the finished packet's fields, unused bits zero
   always @* begin
      trailer_d = 32'h0000_0000;
      trailer_d[`TRL_SPEED_LSB +: 2] = rx_speed_code_i;
      trailer_d[`TRL_PAD_LSB +: 2]   = pad_byte_count_i;
      trailer_d[`TRL_ACK_LSB +: 4]   = returned_ack_code_i;
   end

   // asynchronous trailer capture at the end of each packet
   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         trailer_q <= `RST_ASYNC_RX_TRAILER;
      end else if (async_done_i) begin
         trailer_q <= trailer_d;
      end
   end

   // isochronous header capture, fields already in register order
   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         header_q <= `RST_ISO_RX_HEADER;
      end else if (iso_hdr_valid_i) begin
         header_q <= iso_hdr_i;
      end
   end

   // last delivered receive quadlet, replayed on an empty read
   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         rx_last_q <= `RST_ISO_RX_LAST;
      end else if (rx_pop) begin
         rx_last_q <= rx_head;
      end
   end

   // count of whole packets released but not yet fully drained
   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         released_q <= {`FIFO_CW{1'b0}};
      end else begin
         case ({tx_push && hit_last, tx_pop && tx_head[32]})
            2'b10:   released_q <= released_q + 9'h001;
            2'b01:   released_q <= released_q - 9'h001;
            default: released_q <= released_q;
         endcase
      end
   end

   // transmit output stage toward the link
   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         tx_valid_q <= 1'b0;
         tx_data_q  <= 32'h0000_0000;
         tx_last_q  <= 1'b0;
      end else if (tx_pop) begin
         tx_valid_q <= 1'b1;
         tx_data_q  <= tx_head[31:0];
         tx_last_q  <= tx_head[32];
      end else if (tx_ready_i) begin
         tx_valid_q <= 1'b0;
      end
   end

   // receive ready, exact for the following cycle
   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         rx_ready_q <= 1'b0;
      end else begin
         rx_ready_q <= ({3'b000, rx_count_d} < rx_cap);
      end
   end

   // read data selection, unmapped and write-only offsets read as zero
   always @* begin
      rd_mux = 32'h0000_0000;
      case (reg_addr_i)
         `OFF_ASYNC_RX_TRAILER: rd_mux = trailer_q;
         `OFF_ISO_FIFO_SIZE: begin
            rd_mux[`SZ_TX_LSB +: `SZ_W] = iso_tx_depth_q;
            rd_mux[`SZ_RX_LSB +: `SZ_W] = iso_rx_depth_q;
         end
         `OFF_ISO_FIFO_LEVEL: begin
            rd_mux[`LVL_TX_LSB +: `LVL_W] = iso_tx_free_count;
            rd_mux[`LVL_RX_LSB +: `LVL_W] = iso_rx_fill_count;
         end
         `OFF_ISO_RX_POP: begin
            if (rx_has_data) begin
               rd_mux = rx_head;
            end else begin
               rd_mux = rx_last_q;
            end
         end
         `OFF_ISO_RX_HEADER: rd_mux = header_q;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // read data stand only in the cycle after the strobe
   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         rdata_q <= 32'h0000_0000;
      end else if (reg_rd_i) begin
         rdata_q <= rd_mux;
      end else begin
         rdata_q <= 32'h0000_0000;
      end
   end

   // outputs
   assign reg_rdata_o = rdata_q;
   assign tx_data_o   = tx_data_q;
   assign tx_last_o   = tx_last_q;
   assign tx_valid_o  = tx_valid_q;
   assign rx_ready_o  = rx_ready_q;

endmodule // bulk_iso_fifo_host_port

// File: bulk_iso_regs.vh
/*
 * Register offsets, field positions, reset values and buffer depth of the
 * bulky isochronous host port. Assumes byte addressing on a plain register
 * port with 32-bit data; fields use bit 0 as the most significant bit in the
 * register map, translated here to ordinary Verilog bit indices.
 */
`ifndef BULK_ISO_REGS_VH
`define BULK_ISO_REGS_VH

// register byte offsets
`define OFF_ASYNC_RX_TRAILER     12'h128
`define OFF_ISO_FIFO_SIZE        12'h12C
`define OFF_ISO_FIFO_LEVEL       12'h130
`define OFF_ISO_TX_PUSH_CONTINUE 12'h134
`define OFF_ISO_TX_PUSH_LAST     12'h138
`define OFF_ISO_RX_POP           12'h13C
`define OFF_ISO_RX_HEADER        12'h140

// reset values
`define RST_ASYNC_RX_TRAILER     32'h0000_0000
`define RST_ISO_FIFO_SIZE        32'h0000_0000
`define RST_ISO_RX_HEADER        32'h0000_0000
`define RST_ISO_RX_LAST          32'h0000_0000

// trailer fields (lsb position, msb-first bits 14-15, 22-23, 28-31)
`define TRL_SPEED_LSB            16
`define TRL_PAD_LSB              8
`define TRL_ACK_LSB              0

// size fields (msb-first bits 06-15 and 22-31), 10 bits each
`define SZ_TX_LSB                16
`define SZ_RX_LSB                0
`define SZ_W                     10

// level fields (msb-first bits 04-15 and 20-31), 12 bits each
`define LVL_TX_LSB               16
`define LVL_RX_LSB               0
`define LVL_W                    12

// physical buffer depth in quadlets and its pointer width
`define FIFO_DEPTH               256
`define FIFO_AW                  8
`define FIFO_CW                  9

// capacity clip, sized like the 12-bit level fields
`define FIFO_CAP                 12'h100

`endif

// File: iso_quad_fifo.v
/*
 * Quadlet store shared by the transmit and receive paths: a circular array
 * with write and read enables, a combinational head word and a fill count.
 * Assumes the caller never writes when full nor reads when empty.
 */
`timescale 1ns/1ps
`include "bulk_iso_regs.vh"

module iso_quad_fifo #(
   parameter W = 32
) (
   input  wire                  sys_clk_i,
   input  wire                  sys_rst_i,
   input  wire                  wr_en_i,
   input  wire [W-1:0]          wr_data_i,
   input  wire                  rd_en_i,
   output wire [W-1:0]          head_o,
   output wire [`FIFO_CW-1:0]   count_o
);

   reg [W-1:0]          mem [0:`FIFO_DEPTH-1];
   reg [`FIFO_AW-1:0]   wr_ptr_q;
   reg [`FIFO_AW-1:0]   rd_ptr_q;
   reg [`FIFO_CW-1:0]   count_q;

   assign head_o  = mem[rd_ptr_q];
   assign count_o = count_q;

   // storage array, written without reset
   always @(posedge sys_clk_i) begin
      if (wr_en_i) begin
         mem[wr_ptr_q] <= wr_data_i;
      end
   end

   // pointers and fill count
   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         wr_ptr_q <= {`FIFO_AW{1'b0}};
         rd_ptr_q <= {`FIFO_AW{1'b0}};
         count_q  <= {`FIFO_CW{1'b0}};
      end else begin
         if (wr_en_i) begin
            wr_ptr_q <= wr_ptr_q + 8'h01;
         end
         if (rd_en_i) begin
            rd_ptr_q <= rd_ptr_q + 8'h01;
         end
         if (wr_en_i && !rd_en_i) begin
            count_q <= count_q + 9'h001;
         end else if (rd_en_i && !wr_en_i) begin
            count_q <= count_q - 9'h001;
         end
      end
   end

endmodule // iso_quad_fifo

// File: bulk_iso_chk.sv
/* checker for the iso host port: read answer timing, transmit hold and
   release, captured trailer, header and size readback; assumes one clock
   and a synchronous active-high reset */
`timescale 1ns/1ps
module bulk_iso_chk (
   input wire        sys_clk_i,
   input wire        sys_rst_i,
   input wire [11:0] reg_addr_i,
   input wire [31:0] reg_wdata_i,
   input wire        reg_wr_i,
   input wire        reg_rd_i,
   input wire [31:0] reg_rdata_o,
   input wire [31:0] tx_data_o,
   input wire        tx_last_o,
   input wire        tx_valid_o,
   input wire        tx_ready_i,
   input wire        rx_ready_o,
   input wire [31:0] iso_hdr_i,
   input wire        iso_hdr_valid_i,
   input wire [1:0]  rx_speed_code_i,
   input wire [1:0]  pad_byte_count_i,
   input wire [3:0]  returned_ack_code_i,
   input wire        async_done_i
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   reg  [7:0] rel_q;
   wire       rel_wr = reg_wr_i && reg_addr_i == 12'h138;
   wire       end_tk = tx_valid_o && tx_ready_i && tx_last_o;
   // packets released by a last write and not yet fully sent
   always @(posedge sys_clk_i) begin
      if (sys_rst_i) rel_q <= 8'h00;
      else rel_q <= rel_q + {7'h00, rel_wr} - {7'h00, end_tk};
   end
   a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
      else $error("read data not zero outside a read answer");
   a_rst_clear: assert property ($past(sys_rst_i) |->
      !tx_valid_o && !rx_ready_o && reg_rdata_o == 32'h0)
      else $error("outputs not cleared by reset");
   a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o
      && $stable(tx_data_o) && $stable(tx_last_o))
      else $error("transmit quadlet changed before taken");
   a_tx_released: assert property (tx_valid_o |-> rel_q != 8'h00)
      else $error("transmit quadlet offered before release");
   a_trailer_read: assert property (async_done_i ##1
      (reg_rd_i && reg_addr_i == 12'h128 && !async_done_i) |=> reg_rdata_o ==
      {14'h0, $past(rx_speed_code_i, 2), 6'h0, $past(pad_byte_count_i, 2),
      4'h0, $past(returned_ack_code_i, 2)})
      else $error("trailer readback wrong");
   a_header_read: assert property (iso_hdr_valid_i ##1
      (reg_rd_i && reg_addr_i == 12'h140 && !iso_hdr_valid_i)
      |=> reg_rdata_o == $past(iso_hdr_i, 2))
      else $error("header readback wrong");
   a_size_read: assert property (reg_wr_i && reg_addr_i == 12'h12C ##2
      (reg_rd_i && reg_addr_i == 12'h12C && !$past(reg_wr_i))
      |=> reg_rdata_o == ($past(reg_wdata_i, 3) & 32'h03FF03FF))
      else $error("size readback wrong");
   a_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 12'h144
      |=> reg_rdata_o == 32'h0)
      else $error("unmapped read not zero");
   c_tx_end: cover property (end_tk);
   c_rx_full: cover property ($fell(rx_ready_o));
   c_trl_read: cover property (reg_rd_i && reg_addr_i == 12'h128);
endmodule // bulk_iso_chk
bind bulk_iso_fifo_host_port bulk_iso_chk bulk_iso_chk_inst (.sys_clk_i, .sys_rst_i,
   .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .tx_data_o,
   .tx_last_o, .tx_valid_o, .tx_ready_i, .rx_ready_o, .iso_hdr_i, .iso_hdr_valid_i,
   .rx_speed_code_i, .pad_byte_count_i, .returned_ack_code_i, .async_done_i);

// File: link_model.sv
/* link side model: logs transmit quadlets with their end tag and offers
   receive quadlets on request; assumes the port's system clock */
`timescale 1ns/1ps
module link_model (
   input  wire        sys_clk_i,
   input  wire        stall_i,
   input  wire [31:0] tx_data_i,
   input  wire        tx_last_i,
   input  wire        tx_valid_i,
   output wire        tx_ready_o,
   output reg  [31:0] rx_data_o,
   output reg         rx_valid_o,
   input  wire        rx_ready_i
);
   reg [32:0] got [$];
   integer    n;
   integer    n_late = 0;
   initial begin
      rx_data_o = 32'h0;
      rx_valid_o = 1'b0;
   end
   // link takes no transmit quadlet while stalled
   assign tx_ready_o = !stall_i;
   // log each quadlet taken
   always @(posedge sys_clk_i) begin
      if (tx_valid_i && tx_ready_o) got.push_back({tx_last_i, tx_data_i});
   end
   // offer one quadlet and hold it until the port has room or 50 cycles have passed
   task send(input [31:0] v);
      begin
         rx_data_o <= v;
         rx_valid_o <= 1'b1;
         n = 0;
         #1;
         while (!rx_ready_i && n < 50) begin
            n = n + 1;
            @(posedge sys_clk_i);
            #1;
         end
         if (!rx_ready_i) begin
            n_late = n_late + 1; // ready never came within the bound
         end
         @(posedge sys_clk_i);
         rx_valid_o <= 1'b0;
         rx_data_o <= ~v; // released data shows no stale value
         @(posedge sys_clk_i);
      end
   endtask
endmodule // link_model

// File: tb_top.sv
/* testbench of the iso host port: register tasks, link model traffic,
   captures and reset; assumes a 10 MHz clock */
`timescale 1ns/1ps
module tb_top;
   reg         sys_clk_i = 1'b0;
   reg         sys_rst_i = 1'b1;
   reg  [11:0] reg_addr_i = 12'h0;
   reg  [31:0] reg_wdata_i = 32'h0;
   reg         reg_wr_i = 1'b0;
   reg         reg_rd_i = 1'b0;
   reg  [31:0] iso_hdr_i = 32'h0;
   reg         iso_hdr_valid_i = 1'b0;
   reg  [1:0]  rx_speed_code_i = 2'h0;
   reg  [1:0]  pad_byte_count_i = 2'h0;
   reg  [3:0]  returned_ack_code_i = 4'h0;
   reg         async_done_i = 1'b0;
   reg         stall = 1'b1;
   reg  [27:0] acks = 28'h12456DE;
   reg  [31:0] d;
   wire [31:0] reg_rdata_o, tx_data_o, rx_data_i;
   wire        tx_last_o, tx_valid_o, tx_ready_i, rx_valid_i, rx_ready_o;
   integer     n_fail = 0;
   integer     total_checks = 0;
   integer     i;
   bulk_iso_fifo_host_port bulk_iso_fifo_host_port_inst (.sys_clk_i, .sys_rst_i,
      .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .tx_data_o,
      .tx_last_o, .tx_valid_o, .tx_ready_i, .rx_data_i, .rx_valid_i, .rx_ready_o,
      .iso_hdr_i, .iso_hdr_valid_i, .rx_speed_code_i, .pad_byte_count_i,
      .returned_ack_code_i, .async_done_i);
   link_model link_model_inst (.sys_clk_i, .stall_i(stall), .tx_data_i(tx_data_o),
      .tx_last_i(tx_last_o), .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i),
      .rx_data_o(rx_data_i), .rx_valid_o(rx_valid_i), .rx_ready_i(rx_ready_o));
   initial begin
      forever #50 sys_clk_i = ~sys_clk_i;
   end
   task chk(input [31:0] seen, input [31:0] e, input [8*8:1] w);
      begin
         total_checks = total_checks + 1;
         if (seen !== e) begin
            n_fail = n_fail + 1;
            $display("wrong value %0s expected %h seen %h", w, e, seen);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", total_checks, n_fail);
         if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
         else $display("[ FAIL ]");
         $finish;
      end
   endtask
   // a receive offer that never found room ends the run
   task late_check;
      begin
         if (link_model_inst.n_late != 0) begin
            n_fail = n_fail + 1;
            give_verdict;
         end
      end
   endtask
   // one write cycle then one idle cycle
   task wr(input [11:0] a, input [31:0] v);
      begin
         reg_addr_i <= a;
         reg_wdata_i <= v;
         reg_wr_i <= 1'b1;
         @(posedge sys_clk_i);
         reg_wr_i <= 1'b0;
         @(posedge sys_clk_i);
      end
   endtask
   // read strobe, data sampled in the following cycle
   task rdc(input [11:0] a, input [31:0] e, input [8*8:1] w);
      begin
         reg_addr_i <= a;
         reg_rd_i <= 1'b1;
         @(posedge sys_clk_i);
         reg_rd_i <= 1'b0;
         #1;
         d = reg_rdata_o;
         chk(d, e, w);
         @(posedge sys_clk_i);
      end
   endtask
   task chk_reset;
      begin
         for (i = 0; i < 3; i = i + 1) rdc(12'h128 + {i[9:0], 2'b00}, 32'h0, "reg");
         rdc(12'h140, 32'h0, "header");
         rdc(12'h144, 32'h0, "unmapped");
         rdc(12'h13C, 32'h0, "pop");
         $display("reset test done");
      end
   endtask
   initial begin
      repeat (6) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge sys_clk_i);
      chk_reset;
      wr(12'h12C, 32'hFC02FC01);
      rdc(12'h12C, 32'h00020001, "size");
      rdc(12'h130, 32'h00080000, "level");
      // packet held back until the last write, link stalled
      wr(12'h134, 32'hA0000001);
      wr(12'h134, 32'hA0000002);
      rdc(12'h130, 32'h00060000, "level");
      #1;
      chk({31'h0, tx_valid_o}, 32'h0, "txheld");
      @(posedge sys_clk_i);
      wr(12'h138, 32'hA0000003);
      repeat (3) @(posedge sys_clk_i);
      stall <= 1'b0;
      for (i = 0; i < 20 && link_model_inst.got.size() < 3; i = i + 1) @(posedge sys_clk_i);
      if (link_model_inst.got.size() < 3) begin
         n_fail = n_fail + 1;
         give_verdict;
      end
      for (i = 0; i < 3; i = i + 1) begin
         chk(link_model_inst.got[i][31:0], 32'hA0000001 + i, "txdata");
         chk({31'h0, link_model_inst.got[i][32]}, {31'h0, i == 2}, "txlast");
      end
      rdc(12'h130, 32'h00080000, "level");
      $display("transmit test done");
      for (i = 0; i < 3; i = i + 1) link_model_inst.send(32'hB0000000 + i);
      late_check;
      rdc(12'h130, 32'h00080003, "level");
      for (i = 0; i < 3; i = i + 1) rdc(12'h13C, 32'hB0000000 + i, "pop");
      rdc(12'h13C, 32'hB0000002, "replay");
      rdc(12'h130, 32'h00080000, "level");
      for (i = 0; i < 4; i = i + 1) link_model_inst.send(32'hC0000000 + i);
      late_check;
      #1;
      chk({31'h0, rx_ready_o}, 32'h0, "rxready");
      @(posedge sys_clk_i);
      rdc(12'h130, 32'h00080004, "level");
      $display("receive test done");
      // every listed ack code with varied speed and pad
      for (i = 0; i < 7; i = i + 1) begin
         rx_speed_code_i <= i[1:0];
         pad_byte_count_i <= i[2:1];
         returned_ack_code_i <= acks[4*i +: 4];
         async_done_i <= 1'b1;
         @(posedge sys_clk_i);
         async_done_i <= 1'b0;
         rdc(12'h128, {14'h0, i[1:0], 6'h0, i[2:1], 4'h0, acks[4*i +: 4]}, "trailer");
      end
      iso_hdr_i <= 32'h01234A5F;
      iso_hdr_valid_i <= 1'b1;
      @(posedge sys_clk_i);
      iso_hdr_valid_i <= 1'b0;
      rdc(12'h140, 32'h01234A5F, "header");
      $display("capture test done");
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge sys_clk_i);
      chk_reset;
      give_verdict;
   end
endmodule // tb_top
